//--- cmdc_defs.vh
`ifndef CMDC_DEFS_VH
`define CMDC_DEFS_VH
// timebase tick period and derived counts at 200 MHz
`define CMDC_CLK_HZ           200000000
`define CMDC_TICK_US          1000
`define CMDC_TICK_CYCLES      (`CMDC_CLK_HZ / 1000000 * `CMDC_TICK_US)
`define CMDC_SHIFT_MS         64
`define CMDC_SHIFT_TICKS      (`CMDC_SHIFT_MS * 1000 / `CMDC_TICK_US)
`define CMDC_WDOG_S           50
`define CMDC_WDOG_TICKS       (`CMDC_WDOG_S * 1000000 / `CMDC_TICK_US)
// input current limit codes, mA
`define CMDC_INPUT_LIMIT_SET_PIN_100         12'h064
`define CMDC_INPUT_LIMIT_SET_PIN_500         12'h1F4
`define CMDC_INPUT_LIMIT_SET_PIN_2000        12'h7D0
`define CMDC_INPUT_LIMIT_SET_PIN_ZERO        12'h000
// input threshold codes, mV
`define CMDC_INPUT_THRESHOLD_SET_PIN_4360        13'h1108
`define CMDC_INPUT_THRESHOLD_SET_PIN_4680        13'h1248
`define CMDC_INPUT_THRESHOLD_SET_PIN_NONE        13'h0000
// system rail detection targets, mV
`define CMDC_VSYS_HI          13'h1068
`define CMDC_VSYS_LO          13'h0E88
// charge done margin: 3.5 percent as 35 per 1000
`define CMDC_DONE_PERMILLE    35
// detection states
`define CMDC_DET_CHECK        2'h0
`define CMDC_DET_HI           2'h1
`define CMDC_DET_LO           2'h2
`define CMDC_DET_DONE         2'h3
// loop index
`define CMDC_LOOP_CC          3'h0
`define CMDC_LOOP_CYC         3'h6
`endif

//--- cmdc_timer.v
`include "cmdc_defs.vh"
module cmdc_timer #(
  parameter WIDTH = 26
) (
  // clock and reset
  input  wire             sys_clk,
  input  wire             rst,
  // control
  input  wire             clear,
  input  wire             tick,
  input  wire [WIDTH-1:0] limit,
  // status
  output reg              expired
);
  reg [WIDTH-1:0] count;

  always @(posedge sys_clk)
  begin
    if (rst || clear)
    begin
      count   <= {WIDTH{1'b0}};
      expired <= 1'b0;
    end
    else if (tick && !expired)
    begin
      if (count + 1'b1 >= limit)
        expired <= 1'b1;
      count <= count + 1'b1;
    end
  end
endmodule

//--- cmdc_control.v
// Summary of operation
// [R1] during detection the rail target toggles every 64 ms
// [R2] three detection states; first checks termination with battery present
// [R3] second and third states command 4.2 V then 3.72 V
// [R4] comparator checked in each detection state for battery insertion
// [R5] alternation continues until a battery is detected
// [R6] active loop is the one with the smallest duty cycle demand
// [R7] select pins decode to 500mA/ext/100mA/hi-z with matching threshold
// [R8] threshold and limit always update together from the pins
// [R9] once power good, run from host values if a command was received; code keeps the pin decode while the select pins pick hi-z
// [R10] stand-alone limit comes from the decoded select pins
// [R11] watchdog expiry returns to stand-alone with default settings
// [R12] shorted limit pin gives 2 A; shorted threshold pin gives 4.68 V
// [R13] shorted charge current pin flags a fault and suspends charge
// [R14] floating limit pin with register current setting gives zero charge
// [R15] voltage mode for current regulation, current mode otherwise; code sets current mode on min system reg, batreg or charge done
// [R16] watchdog times out after 50 s without host write
// [R17] each host write restarts the watchdog
// [R18] timers count a fixed tick and clear on entry to their state
// [R19] default mode after reset, host mode on first command
`include "cmdc_defs.vh"
module cmdc_control #(
  parameter SHIFT_TICKS = `CMDC_SHIFT_TICKS,
  parameter WDOG_TICKS  = `CMDC_WDOG_TICKS,
  parameter TICK_CYCLES = `CMDC_TICK_CYCLES
) (
  // clock and reset
  input  wire        sys_clk,
  input  wire        rst,
  // pins and analog status
  input  wire        limit_select_low,
  input  wire        limit_select_high,
  input  wire        input_limit_short,
  input  wire        input_limit_open,
  input  wire        input_threshold_short,
  input  wire        charge_current_short,
  input  wire        power_good,
  input  wire        charge_terminated,
  input  wire        battery_present_cmp,
  // host side
  input  wire        host_write,
  input  wire        watchdog_enable,
  input  wire [11:0] host_input_limit,
  input  wire [12:0] host_threshold,
  input  wire        host_ext_charge_set,
  input  wire [11:0] ext_input_limit,
  input  wire [12:0] ext_threshold,
  // loop demands, one byte each, cc cv minimum_system_regulation input_limit_set_pin input_threshold_set_pin temp cycle
  input  wire [55:0] loop_duty,
  input  wire [12:0] vsys_mv,
  input  wire [12:0] vbat_mv,
  input  wire        minimum_system_regulation_active,
  input  wire        batreg_active,
  // outputs
  output reg         host_mode,
  output reg  [11:0] input_limit,
  output reg  [12:0] input_voltage_power_threshold,
  output reg         input_hiz,
  output reg         charge_fault,
  output reg         charge_suspend,
  output reg         zero_charge,
  output reg  [12:0] vsys_target,
  output reg         detect_active,
  output reg         battery_detected,
  output reg  [2:0]  active_loop,
  output reg         current_mode
);
  // one ms timebase
  reg  [17:0] tick_cnt; // 18 bits so a 1 ms tick at 200 MHz fits
  reg         tick;
  always @(posedge sys_clk)
  begin
    if (rst || tick_cnt == TICK_CYCLES - 1)
      tick_cnt <= 18'h00000;
    else
      tick_cnt <= tick_cnt + 18'h00001;
    tick <= !rst && (tick_cnt == TICK_CYCLES - 1); // see [R18]
  end

  // detection sequencer
  reg  [1:0] det_state;
  reg        shift_clear;
  wire       shift_done;
  cmdc_timer #(.WIDTH(26)) u_shift (
    .sys_clk (sys_clk),
    .rst     (rst),
    .clear   (shift_clear),
    .tick    (tick),
    .limit   (SHIFT_TICKS[25:0]),
    .expired (shift_done)
  );

  always @(posedge sys_clk)
  begin
    shift_clear <= 1'b0;
    if (rst)
    begin
      det_state        <= `CMDC_DET_CHECK;
      battery_detected <= 1'b0;
      shift_clear      <= 1'b1;
    end
    else
    begin
      case (det_state)
        `CMDC_DET_CHECK:
        begin
          if (charge_terminated)
          begin
            if (battery_present_cmp) // see [R2]
              battery_detected <= 1'b1;
            else
            begin
              battery_detected <= 1'b0;
              det_state        <= `CMDC_DET_HI;
              shift_clear      <= 1'b1; // see [R18]
            end
          end
        end
        `CMDC_DET_HI, `CMDC_DET_LO:
        begin
          // checked in both levels so a cell at one threshold is seen
          if (battery_present_cmp) // see [R4]
          begin
            battery_detected <= 1'b1;
            det_state        <= `CMDC_DET_DONE;
          end
          else if (shift_done && !shift_clear) // see [R1] [R5]
          begin
            det_state   <= (det_state == `CMDC_DET_HI) ?
                           `CMDC_DET_LO : `CMDC_DET_HI;
            shift_clear <= 1'b1;
          end
        end
        `CMDC_DET_DONE:
        begin
          if (!charge_terminated)
            det_state <= `CMDC_DET_CHECK;
        end
        default:
          det_state <= `CMDC_DET_CHECK;
      endcase
    end
  end

  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      vsys_target   <= `CMDC_VSYS_HI;
      detect_active <= 1'b0;
    end
    else
    begin
      detect_active <= (det_state == `CMDC_DET_HI) ||
                       (det_state == `CMDC_DET_LO);
      vsys_target   <= (det_state == `CMDC_DET_LO) ?
                       `CMDC_VSYS_LO : `CMDC_VSYS_HI; // see [R3]
    end
  end

  // watchdog and mode arbiter
  wire wd_expired;
  cmdc_timer #(.WIDTH(26)) u_wdog (
    .sys_clk (sys_clk),
    .rst     (rst),
    .clear   (host_write || !watchdog_enable), // see [R17]
    .tick    (tick),
    .limit   (WDOG_TICKS[25:0]), // see [R16]
    .expired (wd_expired)
  );

  always @(posedge sys_clk)
  begin
    if (rst)
      host_mode <= 1'b0; // see [R19]
    else if (host_write)
      host_mode <= 1'b1; // see [R19]
    else if (watchdog_enable && wd_expired)
      host_mode <= 1'b0; // see [R11]
  end

  // pin decode, limit and threshold as one pair
  reg  [11:0] next_limit;
  reg  [12:0] next_threshold;
  reg         next_hiz;
  always @*
  begin
    next_hiz = 1'b0;
    case ({limit_select_high, limit_select_low}) // see [R7] [R8]
      2'b00:
      begin
        next_limit     = `CMDC_INPUT_LIMIT_SET_PIN_500;
        next_threshold = `CMDC_INPUT_THRESHOLD_SET_PIN_4360;
      end
      2'b01:
      begin
        next_limit     = input_limit_short ? `CMDC_INPUT_LIMIT_SET_PIN_2000 :
                         ext_input_limit; // see [R12]
        next_threshold = input_threshold_short ? `CMDC_INPUT_THRESHOLD_SET_PIN_4680 :
                         ext_threshold; // see [R12]
      end
      2'b10:
      begin
        next_limit     = `CMDC_INPUT_LIMIT_SET_PIN_100;
        next_threshold = `CMDC_INPUT_THRESHOLD_SET_PIN_4360;
      end
      default:
      begin
        next_limit     = `CMDC_INPUT_LIMIT_SET_PIN_ZERO;
        next_threshold = `CMDC_INPUT_THRESHOLD_SET_PIN_NONE;
        next_hiz       = 1'b1;
      end
    endcase
    // host values only with power good and host mode
    if (power_good && host_mode && !next_hiz) // see [R9]
    begin
      next_limit     = host_input_limit;
      next_threshold = host_threshold;
    end
    // otherwise stand-alone keeps the pin decode, see [R10]
  end

  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      input_limit                   <= `CMDC_INPUT_LIMIT_SET_PIN_ZERO;
      input_voltage_power_threshold <= `CMDC_INPUT_THRESHOLD_SET_PIN_NONE;
      input_hiz                     <= 1'b1;
      charge_fault                  <= 1'b0;
      charge_suspend                <= 1'b0;
      zero_charge                   <= 1'b0;
    end
    else
    begin
      input_limit                   <= next_limit; // see [R10]
      input_voltage_power_threshold <= next_threshold;
      input_hiz                     <= next_hiz;
      charge_fault                  <= charge_current_short; // see [R13]
      charge_suspend                <= charge_current_short; // see [R13]
      zero_charge                   <= input_limit_open && // see [R14]
                                       host_mode && host_ext_charge_set;
    end
  end

  // loop selection: smallest duty wins, lower index on ties
  reg [7:0] best_duty;
  reg [2:0] best_idx;
  integer   i;
  always @*
  begin
    best_duty = loop_duty[7:0];
    best_idx  = `CMDC_LOOP_CC;
    for (i = 1; i < 7; i = i + 1)
      if (loop_duty[i*8 +: 8] < best_duty) // see [R6]
      begin
        best_duty = loop_duty[i*8 +: 8];
        best_idx  = i[2:0];
      end
  end

  // charge done: vsys at vbat plus 3.5 percent or above
  // 24 bits: full-scale vbat times 1035 would overflow 23
  wire [23:0] vbat_scaled = {11'h000, vbat_mv} * 24'h00040B;
  wire [23:0] vsys_scaled = {11'h000, vsys_mv} * 24'h0003E8;
  wire        charge_done = vsys_scaled >= vbat_scaled;

  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      active_loop  <= `CMDC_LOOP_CC;
      current_mode <= 1'b0;
    end
    else
    begin
      active_loop  <= best_idx;
      current_mode <= minimum_system_regulation_active || batreg_active ||
                      charge_done; // see [R15]
    end
  end
endmodule

//--- cmdc_control_sva.sv
`include "cmdc_defs.vh"
module cmdc_control_sva (
  // clock, reset, pins
  input wire        sys_clk, rst, limit_select_low, limit_select_high,
  input wire        power_good, input_limit_short, input_threshold_short,
  input wire        charge_current_short, host_write, minimum_system_regulation_active,
  input wire        battery_present_cmp,
  input wire [11:0] ext_input_limit,
  input wire [12:0] ext_threshold,
  // watched outputs
  input wire        host_mode, input_hiz, charge_fault, charge_suspend,
  input wire        detect_active, current_mode,
  input wire [11:0] input_limit,
  input wire [12:0] input_voltage_power_threshold, vsys_target
);
  timeunit 1ns;
  timeprecision 1ps;
  wire [1:0] sel = {limit_select_high, limit_select_low};
  wire [12:0] thr = input_voltage_power_threshold;
  // host values only apply with power good, so gate them out
  wire sa = !power_good;
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_hiz_select: assert property (
    sel == 2'h3 |=> input_hiz && thr == `CMDC_INPUT_THRESHOLD_SET_PIN_NONE)
    else $error("hiz select not honoured");
  a_low_select: assert property (
    sa && sel == 2'h2 |=> input_limit == `CMDC_INPUT_LIMIT_SET_PIN_100 &&
    thr == `CMDC_INPUT_THRESHOLD_SET_PIN_4360) else $error("100 mA select wrong");
  a_ext_pair: assert property (
    sa && sel == 2'h1 && !input_limit_short && !input_threshold_short
    |=> input_limit == $past(ext_input_limit) && thr == $past(ext_threshold))
    else $error("external pair not applied");
  a_short_limit: assert property (
    sa && sel == 2'h1 && input_limit_short |=> input_limit == `CMDC_INPUT_LIMIT_SET_PIN_2000)
    else $error("shorted limit pin not 2 A");
  a_set_short: assert property (
    sel == 2'h1 && charge_current_short |=> charge_fault && charge_suspend)
    else $error("charge pin short not faulted");
  a_host_entry: assert property (
    host_write |=> host_mode) else $error("host write ignored");
  a_mode_hold: assert property (
    !host_mode && !host_write |=> !host_mode)
    else $error("host mode without write");
  a_rail_level: assert property (
    $rose(detect_active) |-> vsys_target == `CMDC_VSYS_HI)
    else $error("detection rail level wrong");
  a_batt_exit: assert property (
    detect_active && battery_present_cmp |=> ##[0:2] !detect_active)
    else $error("detection not left on insertion");
  a_cur_mode: assert property (
    minimum_system_regulation_active |=> current_mode) else $error("minimum_system_regulation not current mode");
endmodule

//--- cmdc_host_model.sv
module cmdc_host_model #(
  parameter [11:0] LIMIT = 12'h2EE,
  parameter [12:0] THR   = 13'h1130
) (
  input  wire        sys_clk, rst, req, ext_set,
  output reg         host_write,
  output wire [11:0] host_input_limit,
  output wire [12:0] host_threshold,
  output wire        host_ext_charge_set
);
  timeunit 1ns;
  timeprecision 1ps;
  assign host_input_limit = LIMIT;
  assign host_threshold = THR;
  assign host_ext_charge_set = ext_set;
  reg req_q = 1'h0;
  initial host_write = 1'h0;
  // request taken on the rising edge so the bench drive never races it
  always @(posedge sys_clk) req_q <= req && !rst;
  // one write per request; caller writes once inside the watchdog interval, then lets it expire
  always @(negedge sys_clk) host_write <= req_q;
endmodule

//--- test_cmdc_control.sv
module test_cmdc_control;
  timeunit 1ns;
  timeprecision 1ps;
  localparam TC = 4, ST = 3, WT = 10;
  localparam [47:0] ELIM = {12'h000, 12'h064, 12'h3E8, 12'h1F4};
  localparam [51:0] ETHR = {13'h0000, 13'h1108, 13'h1194, 13'h1108};
  localparam [167:0] DUTY = {56'h30301030103030, 56'h30303030303004,
                             56'h05303030303030};
  localparam [8:0] ELOOP = {3'h2, 3'h0, 3'h6};
  reg sys_clk = 0, rst = 1, req = 0, xset = 0, ils = 0, ilo = 0, its = 0;
  reg ccs = 0, pg = 0, term = 0, cmp = 0, wde = 0, mins = 0, breg = 0;
  reg [1:0] sel = 0;
  reg [11:0] xl = 12'h3E8;
  reg [12:0] xt = 13'h1194;
  reg [55:0] duty = 0;
  reg [12:0] vs = 0, vb = 0;
  wire hw, hx, hm, hiz, cf, cs, zc, da, bd, cm;
  wire [11:0] hil, lim;
  wire [12:0] hth, thr, vt;
  wire [2:0] al;
  integer n_fail = 0, comparisons = 0, cyc = 0, i, n;
  initial forever #2.5 sys_clk = ~sys_clk;
  cmdc_host_model host (.sys_clk(sys_clk), .rst(rst), .req(req),
    .ext_set(xset), .host_write(hw), .host_input_limit(hil),
    .host_threshold(hth), .host_ext_charge_set(hx));
  cmdc_control #(.SHIFT_TICKS(ST), .WDOG_TICKS(WT), .TICK_CYCLES(TC)) DUT (
    .sys_clk(sys_clk), .rst(rst), .limit_select_low(sel[0]),
    .limit_select_high(sel[1]), .input_limit_short(ils),
    .input_limit_open(ilo), .input_threshold_short(its),
    .charge_current_short(ccs), .power_good(pg), .charge_terminated(term),
    .battery_present_cmp(cmp), .host_write(hw), .watchdog_enable(wde),
    .host_input_limit(hil), .host_threshold(hth), .host_ext_charge_set(hx),
    .ext_input_limit(xl), .ext_threshold(xt), .loop_duty(duty),
    .vsys_mv(vs), .vbat_mv(vb), .minimum_system_regulation_active(mins), .batreg_active(breg),
    .host_mode(hm), .input_limit(lim), .input_voltage_power_threshold(thr),
    .input_hiz(hiz), .charge_fault(cf), .charge_suspend(cs),
    .zero_charge(zc), .vsys_target(vt), .detect_active(da),
    .battery_detected(bd), .active_loop(al), .current_mode(cm));
  task check(input string nm, input [12:0] seen, input [12:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp)
    begin
      n_fail = n_fail + 1;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task tally_and_finish;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task step(input integer k);
    repeat (k) @(negedge sys_clk);
  endtask
  // counts cycles until the rail target leaves a level
  task wait_rail(input [12:0] from);
    n = 0;
    while (vt === from && n < 40)
    begin
      step(1);
      n = n + 1;
    end
  endtask
  always @(posedge sys_clk)
  begin
    cyc = cyc + 1;
    if (cyc == 3000)
    begin
      n_fail = n_fail + 1;
      tally_and_finish;
    end
  end
  initial
  begin
    step(10);
    check("host_mode", hm, 1'h0);
    check("hiz", hiz, 1'h1);
    check("rail", vt, 13'h1068);
    rst = 0;
    for (i = 0; i < 4; i = i + 1)
    begin
      sel = i[1:0];
      step(2);
      check("limit", lim, ELIM[i*12 +: 12]);
      check("thr", thr, ETHR[i*13 +: 13]);
      check("hiz", hiz, i == 3);
    end
    sel = 1;
    ils = 1;
    its = 1;
    step(2);
    check("limit", lim, 12'h7D0);
    check("thr", thr, 13'h1248);
    ils = 0;
    its = 0;
    ccs = 1;
    xl = 12'h2BC;
    xt = 13'h1180;
    step(2);
    check("fault", {cf, cs}, 2'h3);
    check("limit", lim, 12'h2BC);
    check("thr", thr, 13'h1180);
    ccs = 0;
    pg = 1;
    sel = 2;
    step(2);
    check("fault", cf, 1'h0);
    check("limit", lim, 12'h064);
    sel = 0;
    req = 1;
    step(1);
    req = 0;
    step(2);
    check("host_mode", hm, 1'h1);
    check("limit", lim, 12'h2EE);
    check("thr", thr, 13'h1130);
    ilo = 1;
    xset = 1;
    step(2);
    check("zero", zc, 1'h1);
    ilo = 0;
    wde = 1;
    step(30);
    req = 1;
    step(1);
    req = 0;
    step(29);
    check("host_mode", hm, 1'h1);
    step(20);
    check("host_mode", hm, 1'h0);
    check("limit", lim, 12'h1F4);
    for (i = 0; i < 3; i = i + 1)
    begin
      duty = DUTY[i*56 +: 56];
      step(2);
      check("loop", al, ELOOP[i*3 +: 3]);
    end
    mins = 1;
    step(2);
    check("cmode", cm, 1'h1);
    mins = 0;
    breg = 1;
    step(2);
    check("cmode", cm, 1'h1);
    breg = 0;
    vb = 13'h0FA0;
    vs = 13'h102C;
    step(2);
    check("cmode", cm, 1'h1);
    vs = 13'h1004;
    step(2);
    check("cmode", cm, 1'h0);
    term = 1;
    cmp = 1;
    step(5);
    check("detect", da, 1'h0);
    check("found", bd, 1'h1);
    cmp = 0;
    step(3);
    check("detect", da, 1'h1);
    wait_rail(13'h1068);
    check("rail", vt, 13'h0E88);
    wait_rail(13'h0E88);
    check("rail", vt, 13'h1068);
    check("shift", n >= 10 && n <= 14, 1'h1);
    cmp = 1;
    step(4);
    check("found", {bd, da}, 2'h2);
    tally_and_finish;
  end
endmodule
bind cmdc_control cmdc_control_sva u_sva (.sys_clk(sys_clk), .rst(rst),
  .limit_select_low(limit_select_low), .limit_select_high(limit_select_high),
  .power_good(power_good), .input_limit_short(input_limit_short),
  .input_threshold_short(input_threshold_short), .host_write(host_write),
  .charge_current_short(charge_current_short), .host_mode(host_mode),
  .minimum_system_regulation_active(minimum_system_regulation_active), .battery_present_cmp(battery_present_cmp),
  .ext_input_limit(ext_input_limit), .ext_threshold(ext_threshold),
  .input_hiz(input_hiz), .charge_fault(charge_fault),
  .charge_suspend(charge_suspend), .detect_active(detect_active),
  .current_mode(current_mode), .input_limit(input_limit),
  .input_voltage_power_threshold(input_voltage_power_threshold),
  .vsys_target(vsys_target));
